/* design/spsd_pkg.sv */
// Constants, register map and types for the servo panel status display
package spsd_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned HOLDOFF_MS = 2000;
    localparam int unsigned CHAR_MS = 500;
    localparam int unsigned HOLDOFF_CYC = (CLK_HZ / 1000) * HOLDOFF_MS;
    localparam int unsigned CHAR_CYC = (CLK_HZ / 1000) * CHAR_MS;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ALARM_CODE = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_DISP_CHAR = 8'h14;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int CTRL_DISP_EN_BIT = 0;
    localparam int CTRL_SETUP_BIT = 1;
    localparam logic CTRL_DISP_EN_RESET = 1'b1;

    localparam int STAT_SEG_LSB = 0;
    localparam int STAT_FWD_BIT = 4;
    localparam int STAT_REV_BIT = 5;
    localparam int STAT_BKP_BIT = 6;
    localparam int STAT_HOLD_BIT = 7;
    localparam int STAT_ALARM_BIT = 8;

    localparam int IRQ_W = 5;
    localparam int IRQ_FWD = 0;
    localparam int IRQ_REV = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_BKP = 3;
    localparam int IRQ_LINK = 4;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    // ----------------------------------------------------------------
    // Display characters: values 0 to 15 are hex digits
    // ----------------------------------------------------------------
    typedef logic [4:0] spsd_char_t;
    localparam spsd_char_t CH_P = 5'h10;
    localparam spsd_char_t CH_N = 5'h11;
    localparam spsd_char_t CH_A = 5'h12;
    localparam spsd_char_t CH_DOT = 5'h13;
    localparam spsd_char_t CH_DASH = 5'h14;
    localparam spsd_char_t CH_BLANK = 5'h15;

    localparam int NUM_SLOTS = 4;
    localparam logic [1:0] SLOT_FWD = 2'h0;
    localparam logic [1:0] SLOT_REV = 2'h1;
    localparam logic [1:0] SLOT_CORE = 2'h2;
    localparam logic [1:0] SLOT_BKP = 2'h3;
    localparam logic [2:0] LEN_LIMIT = 3'h1;
    localparam logic [2:0] LEN_ALARM = 3'h5;
    localparam logic [11:0] BACKUP_CODE = 12'h810;

    typedef enum logic {
        ST_NORMAL = 1'b0,
        ST_CODE = 1'b1
    } spsd_state_t;

endpackage

/* design/spsd_tb_if.sv */
// Timebase signals passed from the timebase to the display core
`timescale 1ns/1ps
interface spsd_tb_if;
    logic char_step;
    logic holdoff_done;
    modport src (output char_step, output holdoff_done);
    modport dst (input char_step, input holdoff_done);
endinterface

/* design/spsd_timebase.sv */
// Character step divider and power-up alarm hold-off timer
`timescale 1ns/1ps
module spsd_timebase #(
    parameter int unsigned HOLD_CYC = spsd_pkg::HOLDOFF_CYC,
    parameter int unsigned CHAR_CYC = spsd_pkg::CHAR_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    spsd_tb_if.src tb
);
    import spsd_pkg::*;

    logic [31:0] char_cnt_reg;
    logic [31:0] hold_cnt_reg;

    // ----------------------------------------------------------------
    // Character interval
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            char_cnt_reg <= 32'h0;
            tb.char_step <= 1'b0;
        end else if (char_cnt_reg >= 32'(CHAR_CYC - 1)) begin
            char_cnt_reg <= 32'h0;
            tb.char_step <= 1'b1;
        end else begin
            char_cnt_reg <= char_cnt_reg + 32'h1;
            tb.char_step <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Hold-off after power-up
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_cnt_reg <= 32'h0;
            tb.holdoff_done <= 1'b0;
        end else if (!tb.holdoff_done) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
            tb.holdoff_done <= (hold_cnt_reg >= 32'(HOLD_CYC - 1));
        end
    end

endmodule

/* design/spsd_top.sv */
// Panel status bits, code display sequencer, alarm output and APB registers
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module spsd_top #(
    parameter int unsigned HOLD_CYC = spsd_pkg::HOLDOFF_CYC,
    parameter int unsigned CHAR_CYC = spsd_pkg::CHAR_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motor_rotating,
    input wire logic servo_on,
    input wire logic cmd_receiving,
    input wire logic link_connected,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic fwd_soft_limit_over,
    input wire logic rev_soft_limit_over,
    input wire logic core_alarm,
    input wire logic [11:0] core_alarm_code,
    input wire logic abs_encoder_used,
    input wire logic abs_setup_valid,
    input wire logic battery_data_lost,
    output logic [3:0] status_seg,
    output spsd_pkg::spsd_char_t disp_char,
    output logic alarm_output,
    output logic irq
);
    import spsd_pkg::*;

    spsd_tb_if tb_if ();

    spsd_timebase #(
        .HOLD_CYC(HOLD_CYC),
        .CHAR_CYC(CHAR_CYC)
    ) u_timebase (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tb(tb_if.src)
    );

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic disp_en_reg;
    logic setup_pulse;
    logic fwd_prohibit_reg;
    logic rev_prohibit_reg;
    logic core_alarm_reg;
    logic [11:0] core_code_reg;
    logic backup_err_reg;
    logic first_cycle_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] ev_level;
    logic [IRQ_W-1:0] ev_prev_reg;
    logic [3:0] code_act;
    spsd_state_t state_reg;
    logic [1:0] slot_reg;
    logic [2:0] idx_reg;
    logic apb_access;
    logic wr_take;
    logic [31:0] rd_data;
    logic rd_hit;

    // ----------------------------------------------------------------
    // Status segments
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_seg <= 4'h0;
        end else begin
            status_seg[0] <= motor_rotating;
            status_seg[1] <= ~servo_on;
            status_seg[2] <= cmd_receiving;
            status_seg[3] <= link_connected;
        end
    end

    // ----------------------------------------------------------------
    // Code conditions
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fwd_prohibit_reg <= 1'b0;
            rev_prohibit_reg <= 1'b0;
            core_alarm_reg <= 1'b0;
            core_code_reg <= 12'h000;
        end else begin
            fwd_prohibit_reg <= ~forward_limit_input | fwd_soft_limit_over;
            rev_prohibit_reg <= ~reverse_limit_input | rev_soft_limit_over;
            core_alarm_reg <= core_alarm;
            core_code_reg <= core_alarm_code;
        end
    end

    // Backup error: set at first use or on lost battery data, cleared by setup
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            first_cycle_reg <= 1'b1;
            backup_err_reg <= 1'b0;
        end else begin
            first_cycle_reg <= 1'b0;
            if (first_cycle_reg && abs_encoder_used && !abs_setup_valid) begin
                backup_err_reg <= 1'b1;
            end else if (abs_encoder_used && battery_data_lost) begin
                backup_err_reg <= 1'b1;
            end else if (setup_pulse) begin
                backup_err_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Alarm output
    // ----------------------------------------------------------------
    // Stays low during hold-off so a host that samples early sees nothing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            alarm_output <= 1'b0;
        end else begin
            alarm_output <= tb_if.holdoff_done & (core_alarm_reg | backup_err_reg);
        end
    end

    // ----------------------------------------------------------------
    // Code sequencer
    // ----------------------------------------------------------------
    assign code_act = {backup_err_reg, core_alarm_reg, rev_prohibit_reg, fwd_prohibit_reg};

    function automatic logic [2:0] slot_len(input logic [1:0] slot);
        return (slot == SLOT_FWD || slot == SLOT_REV) ? LEN_LIMIT : LEN_ALARM;
    endfunction

    // First active slot after cur, wrapping round; cur itself comes last
    function automatic logic [1:0] next_slot(input logic [1:0] cur, input logic [3:0] act);
        logic [1:0] res;
        logic found;
        logic [1:0] cand;
        res = cur;
        found = 1'b0;
        for (int k = 1; k <= NUM_SLOTS; k++) begin
            cand = 2'(int'(cur) + k);
            if (!found && act[cand]) begin
                res = cand;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    function automatic spsd_char_t char_of(input logic [1:0] slot, input logic [2:0] idx,
                                           input logic [11:0] code);
        spsd_char_t ch;
        case (idx)
            3'h0: begin
                ch = CH_A;
            end
            3'h1: begin
                ch = CH_DOT;
            end
            3'h2: begin
                ch = {1'b0, code[11:8]};
            end
            3'h3: begin
                ch = {1'b0, code[7:4]};
            end
            default: begin
                ch = {1'b0, code[3:0]};
            end
        endcase
        if (slot == SLOT_FWD) begin
            ch = CH_P;
        end else if (slot == SLOT_REV) begin
            ch = CH_N;
        end
        return ch;
    endfunction

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= ST_NORMAL;
            slot_reg <= SLOT_FWD;
            idx_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_NORMAL: begin
                    if (|code_act) begin
                        state_reg <= ST_CODE;
                        slot_reg <= next_slot(SLOT_BKP, code_act);
                        idx_reg <= 3'h0;
                    end
                end
                ST_CODE: begin
                    if (!(|code_act)) begin
                        state_reg <= ST_NORMAL;
                        idx_reg <= 3'h0;
                    end else if (tb_if.char_step) begin
                        if (idx_reg == slot_len(slot_reg) - 3'h1 || !code_act[slot_reg]) begin
                            slot_reg <= next_slot(slot_reg, code_act);
                            idx_reg <= 3'h0;
                        end else begin
                            idx_reg <= 3'(idx_reg + 3'h1);
                        end
                    end
                end
                default: begin
                    state_reg <= ST_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            disp_char <= CH_BLANK;
        end else if (!disp_en_reg) begin
            disp_char <= CH_BLANK;
        end else if (state_reg == ST_NORMAL) begin
            disp_char <= CH_DASH;
        end else if (slot_reg == SLOT_BKP) begin
            disp_char <= char_of(slot_reg, idx_reg, BACKUP_CODE);
        end else begin
            disp_char <= char_of(slot_reg, idx_reg, core_code_reg);
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign ev_level[IRQ_FWD] = fwd_prohibit_reg;
    assign ev_level[IRQ_REV] = rev_prohibit_reg;
    assign ev_level[IRQ_ALARM] = alarm_output;
    assign ev_level[IRQ_BKP] = backup_err_reg;
    assign ev_level[IRQ_LINK] = link_connected;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ev_prev_reg <= '0;
        end else begin
            ev_prev_reg <= ev_level;
        end
    end

    assign irq_clr = (wr_take && paddr == OFS_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0;

    // Rising edge sets the sticky bit; a set wins over a clear in the same cycle
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
        assign irq_event[i] = ev_level[i] & ~ev_prev_reg[i];
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                irq_status_reg[i] <= 1'b0;
            end else begin
                irq_status_reg[i] <= irq_event[i] | (irq_status_reg[i] & ~irq_clr[i]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign apb_access = psel & penable;
    assign wr_take = apb_access & pready & pwrite;
    assign setup_pulse = wr_take && paddr == OFS_CTRL && pwdata[CTRL_SETUP_BIT];

    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            OFS_CTRL: begin
                rd_data[CTRL_DISP_EN_BIT] = disp_en_reg;
            end
            OFS_STATUS: begin
                rd_data[STAT_SEG_LSB +: 4] = status_seg;
                rd_data[STAT_FWD_BIT] = fwd_prohibit_reg;
                rd_data[STAT_REV_BIT] = rev_prohibit_reg;
                rd_data[STAT_BKP_BIT] = backup_err_reg;
                rd_data[STAT_HOLD_BIT] = tb_if.holdoff_done;
                rd_data[STAT_ALARM_BIT] = alarm_output;
            end
            OFS_ALARM_CODE: begin
                rd_data[11:0] = core_code_reg;
            end
            OFS_IRQ_STATUS: begin
                rd_data[IRQ_W-1:0] = irq_status_reg;
            end
            OFS_IRQ_MASK: begin
                rd_data[IRQ_W-1:0] = irq_mask_reg;
            end
            OFS_DISP_CHAR: begin
                rd_data[4:0] = disp_char;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access & ~pready;
            if (apb_access && !pready) begin
                prdata <= pwrite ? 32'h0 : rd_data;
                pslverr <= ~rd_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            disp_en_reg <= CTRL_DISP_EN_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_take) begin
            if (paddr == OFS_CTRL) begin
                disp_en_reg <= pwdata[CTRL_DISP_EN_BIT];
            end
            if (paddr == OFS_IRQ_MASK) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

endmodule

/* testbench/spsd_monitor.sv */
// Concurrent checks on the ports of the panel status display
`timescale 1ns/1ps
module spsd_monitor #(
    parameter int unsigned HOLD_CYC = 200,
    parameter int unsigned CHAR_CYC = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic motor_rotating,
    input wire logic servo_on,
    input wire logic cmd_receiving,
    input wire logic link_connected,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic fwd_soft_limit_over,
    input wire logic rev_soft_limit_over,
    input wire logic core_alarm,
    input wire logic [3:0] status_seg,
    input wire spsd_pkg::spsd_char_t disp_char,
    input wire logic alarm_output
);
    import spsd_pkg::*;
    int unsigned up_cnt;
    int unsigned fwd_gap;
    int unsigned rev_gap;
    // Cycles since reset, held at HOLD_CYC + 8, and since each prohibit condition was last present
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            up_cnt <= 0;
            fwd_gap <= 0;
            rev_gap <= 0;
        end else begin
            up_cnt <= (up_cnt < HOLD_CYC + 8) ? up_cnt + 1 : up_cnt;
            fwd_gap <= (!forward_limit_input || fwd_soft_limit_over) ? 0 : fwd_gap + 1;
            rev_gap <= (!reverse_limit_input || rev_soft_limit_over) ? 0 : rev_gap + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    seg_rot_a: assert property (
        !$past(sys_rst) |-> status_seg[0] == $past(motor_rotating)) else $error("rotation seg");
    seg_servo_a: assert property (
        !$past(sys_rst) |-> status_seg[1] == !$past(servo_on)) else $error("servo seg");
    seg_cmd_a: assert property (
        !$past(sys_rst) |-> status_seg[2] == $past(cmd_receiving)) else $error("command seg");
    seg_link_a: assert property (
        !$past(sys_rst) |-> status_seg[3] == $past(link_connected)) else $error("link seg");
    fwd_code_a: assert property (
        disp_char == CH_P |-> fwd_gap <= CHAR_CYC + 4) else $error("P without cause");
    rev_code_a: assert property (
        disp_char == CH_N |-> rev_gap <= CHAR_CYC + 4) else $error("n without cause");
    alarm_dot_a: assert property (
        $changed(disp_char) && disp_char == CH_DOT |-> $past(disp_char) == CH_A)
        else $error("dot not after A");
    alarm_hold_a: assert property (
        alarm_output |-> up_cnt >= HOLD_CYC - 4) else $error("alarm during hold-off");
    alarm_set_a: assert property (
        core_alarm [*3] ##0 up_cnt > HOLD_CYC + 4 |-> alarm_output) else $error("alarm missing");
    apb_wait_a: assert property (
        psel && $rose(penable) |=> pready) else $error("pready not after one wait");
    apb_pulse_a: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
endmodule

bind spsd_top spsd_monitor #(.HOLD_CYC(HOLD_CYC), .CHAR_CYC(CHAR_CYC)) mon_u (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
    .motor_rotating(motor_rotating), .servo_on(servo_on), .cmd_receiving(cmd_receiving),
    .link_connected(link_connected), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .fwd_soft_limit_over(fwd_soft_limit_over),
    .rev_soft_limit_over(rev_soft_limit_over), .core_alarm(core_alarm),
    .status_seg(status_seg), .disp_char(disp_char), .alarm_output(alarm_output));

/* testbench/spsd_panel_host.sv */
// Front panel and host alarm input model
`timescale 1ns/1ps
module spsd_panel_host #(
    parameter int unsigned HOLD_CYC = 200
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire spsd_pkg::spsd_char_t disp_char,
    input wire logic alarm_output,
    output logic alarm_seen
);
    import spsd_pkg::*;
    spsd_char_t seen[$];
    int unsigned stamp[$];
    int unsigned cyc;
    spsd_char_t last;
    always @(posedge mclk) begin
        if (sys_rst) begin
            cyc = 0;
            last = CH_BLANK;
            alarm_seen <= 1'b0;
        end else begin
            cyc = cyc + 1;
            // Panel logs each new character with its cycle
            if (disp_char !== last) begin
                seen.push_back(disp_char);
                stamp.push_back(cyc);
                last = disp_char;
            end
            // Host disregards the alarm line during power-up
            if (cyc > HOLD_CYC && alarm_output === 1'b1) begin
                alarm_seen <= 1'b1;
            end
        end
    end
endmodule

/* testbench/servo_panel_status_display_tb.sv */
// Self-checking testbench for the panel status display
`timescale 1ns/1ps
module servo_panel_status_display_tb;
    import spsd_pkg::*;
    localparam int unsigned HC = 200;
    localparam int unsigned CC = 8;
    logic mclk, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, irq, alarm_output, alarm_seen;
    logic mot = 1'b0, son = 1'b1, cmd = 1'b0, lnk = 1'b0, fwd = 1'b1, rev = 1'b1;
    logic fso = 1'b0, rso = 1'b0, c_alarm = 1'b1, abs_u = 1'b0, abs_v = 1'b0, bat = 1'b0;
    logic [11:0] code = 12'he60;
    logic [3:0] status_seg;
    spsd_char_t disp_char;
    spsd_char_t exp_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    int tcnt = 0;

    spsd_top #(.HOLD_CYC(HC), .CHAR_CYC(CC)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_rotating(mot),
        .servo_on(son), .cmd_receiving(cmd), .link_connected(lnk),
        .forward_limit_input(fwd), .reverse_limit_input(rev), .fwd_soft_limit_over(fso),
        .rev_soft_limit_over(rso), .core_alarm(c_alarm), .core_alarm_code(code),
        .abs_encoder_used(abs_u), .abs_setup_valid(abs_v), .battery_data_lost(bat),
        .status_seg(status_seg), .disp_char(disp_char), .alarm_output(alarm_output),
        .irq(irq));
    spsd_panel_host #(.HOLD_CYC(HC)) panel_u (.mclk(mclk), .sys_rst(sys_rst),
        .disp_char(disp_char), .alarm_output(alarm_output), .alarm_seen(alarm_seen));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, got);
            error_cnt++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends once pready is seen high; only the bench timeout ends a wait where it never rises
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, q);
    endtask

    task automatic rst_seq();
        sys_rst <= 1'b1;
        cyc(16);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk("reset disp_char", CH_BLANK, disp_char);
    endtask

    // Looks for exp_q among the logged characters, each but the last standing CC cycles
    task automatic seq(input string nm, input int n);
        int hit;
        int ok;
        panel_u.seen.delete();
        panel_u.stamp.delete();
        cyc(n);
        hit = 0;
        for (int i = 0; i + exp_q.size() <= panel_u.seen.size(); i++) begin
            ok = 1;
            for (int j = 0; j < exp_q.size(); j++) begin
                if (panel_u.seen[i+j] !== exp_q[j]) ok = 0;
                else if (j > 0 && panel_u.stamp[i+j] - panel_u.stamp[i+j-1] != CC) ok = 0;
            end
            if (ok == 1) hit = 1;
        end
        chk(nm, 1, hit);
    endtask

    always @(posedge mclk) begin
        tcnt++;
        if (tcnt > 5000) begin
            error_cnt++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_seq();
        rd(OFS_CTRL, 32'h1, "ctrl reset");
        rd(OFS_IRQ_MASK, 32'h0, "irq_mask reset");
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped pslverr", 1, e);
        chk("unmapped prdata", 0, q);
        exp_q = '{CH_A, CH_DOT, 5'h0e, 5'h06, 5'h00};
        seq("core alarm chars", 10 * CC);
        chk("early alarm_output", 0, alarm_output);
        cyc(HC);
        chk("alarm_output", 1, alarm_output);
        chk("host alarm", 1, alarm_seen);
        rd(OFS_ALARM_CODE, 32'he60, "alarm code");
        rd(OFS_STATUS, 32'h180, "status alarm");
        c_alarm <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {lnk, cmd, son, mot} <= (4'h1 << i) ^ 4'h2;
            cyc(3);
            chk("status_seg", 4'h1 << i, status_seg);
        end
        rd(OFS_IRQ_STATUS, 32'h14, "irq_status");
        chk("masked irq", 0, irq);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1f);
        rd(OFS_IRQ_STATUS, 32'h0, "irq_status cleared");
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        fwd <= 1'b0;
        cyc(CC + 4);
        chk("fwd code", CH_P, disp_char);
        chk("irq", 1, irq);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        cyc(2);
        chk("irq cleared", 0, irq);
        rev <= 1'b0;
        cyc(3);
        exp_q = '{CH_P, CH_N, CH_P, CH_N};
        seq("both limits", 6 * CC);
        fwd <= 1'b1;
        rev <= 1'b1;
        fso <= 1'b1;
        cyc(2 * CC + 4);
        chk("fwd soft code", CH_P, disp_char);
        fso <= 1'b0;
        rso <= 1'b1;
        cyc(2 * CC + 4);
        chk("rev soft code", CH_N, disp_char);
        rso <= 1'b0;
        cyc(2 * CC + 4);
        chk("normal code", CH_DASH, disp_char);
        apb(1'b1, OFS_CTRL, 32'h0);
        cyc(2 * CC);
        chk("display off", CH_BLANK, disp_char);
        apb(1'b1, OFS_CTRL, 32'h1);
        abs_u <= 1'b1;
        rst_seq();
        exp_q = '{CH_A, CH_DOT, 5'h08, 5'h01, 5'h00};
        seq("backup chars", 10 * CC);
        rd(OFS_STATUS, 32'h48, "status backup");
        chk("host alarm after reset", 0, alarm_seen);
        apb(1'b1, OFS_CTRL, 32'h3);
        cyc(2 * CC + 4);
        chk("setup clears", CH_DASH, disp_char);
        rd(OFS_STATUS, 32'h08, "status cleared");
        bat <= 1'b1;
        @(posedge mclk);
        bat <= 1'b0;
        cyc(3);
        rd(OFS_STATUS, 32'h48, "status battery loss");
        conclude();
    end
endmodule
